// ===== fifo_dev_model.sv
// Behavioural model of one strobed FIFO channel
`timescale 1ns/10ps
`default_nettype none

module fifo_dev_model
#(
    parameter int DEPTH = 256
)
(
    // Write side
    input wire logic [8:0] push_word,
    input wire logic push_strobe_n,
    output logic no_room_flag_n,
    // Read side
    output logic [8:0] pop_word,
    input wire logic pop_pulse_n,
    output logic drained_flag_n,
    // Control and mode
    input wire logic clear_pulse_n,
    input wire logic lead_or_replay_n,
    input wire logic chain_in_n,
    output logic chain_or_half_out_n
);
    logic [8:0] mem [DEPTH];
    logic [8:0] last_q = 9'h000;
    logic go_w = 1'b0;
    logic go_r = 1'b0;
    logic half_n = 1'b1;
    logic chain_n = 1'b1;
    int wp = 0;
    int rp = 0;
    int cnt = 0;
    // Released bus shows inverted data so a stale copy never passes
    assign pop_word = (pop_pulse_n || !go_r) ? ~last_q : last_q;
    assign no_room_flag_n = cnt != DEPTH;
    assign drained_flag_n = cnt != 0;
    // Chain pulse spans the push into the last cell; host ignores it
    assign chain_or_half_out_n = chain_in_n ? chain_n : half_n;
    always @(negedge clear_pulse_n)
    begin
        wp = 0;
        rp = 0;
        cnt = 0;
        half_n = 1'b1;
    end
    always @(negedge push_strobe_n)
    begin
        go_w = clear_pulse_n && cnt != DEPTH;
        chain_n = !(go_w && wp == DEPTH - 1);
        if (go_w && cnt >= DEPTH / 2)
            half_n = 1'b0;
    end
    always @(posedge push_strobe_n)
    begin
        if (go_w)
        begin
            mem[wp] = push_word;
            wp = (wp + 1) % DEPTH;
            cnt++;
        end
        go_w = 1'b0;
        chain_n = 1'b1;
    end
    always @(negedge pop_pulse_n)
    begin
        go_r = clear_pulse_n && cnt != 0;
        if (go_r)
            last_q = mem[rp];
    end
    always @(posedge pop_pulse_n)
    begin
        if (go_r)
        begin
            rp = (rp + 1) % DEPTH;
            cnt--;
            if (cnt <= DEPTH / 2)
                half_n = 1'b1;
        end
        go_r = 1'b0;
    end
    always @(negedge lead_or_replay_n)
    begin
        if (!chain_in_n && clear_pulse_n)
        begin
            rp = 0;
            cnt = wp;
            half_n = !(cnt > DEPTH / 2);
        end
    end
endmodule // fifo_dev_model

`default_nettype wire

// ===== fifo_host.sv
// Host controller driving one strobed FIFO channel through its pins
`timescale 1ns/10ps
`default_nettype none
`include "fifo_host_defs.svh"

module fifo_host
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Command port
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [`DATA_W-1:0] rdata,
    // FIFO write side
    output logic [`WORD_W-1:0] push_word,
    output logic push_strobe_n,
    input wire logic no_room_flag_n,
    // FIFO read side
    input wire logic [`WORD_W-1:0] pop_word,
    output logic pop_pulse_n,
    input wire logic drained_flag_n,
    // FIFO control and mode pins
    output logic clear_pulse_n,
    output logic lead_or_replay_n,
    output logic chain_in_n,
    input wire logic chain_or_half_out_n
);

    fifo_host_pkg::state_type state_reg, state_next;
    logic [3:0] count_reg, count_next;
    logic [`WORD_W-1:0] push_word_reg, push_word_next;
    logic [`WORD_W-1:0] pop_data_reg, pop_data_next;
    logic pop_valid_reg, pop_valid_next;
    logic cleared_reg, cleared_next;
    logic refused_reg, refused_next;
    fifo_host_pkg::mode_type mode_reg, mode_next;
    logic push_n_reg, push_n_next;
    logic pop_n_reg, pop_n_next;
    logic clear_n_reg, clear_n_next;
    logic replay_n_reg, replay_n_next;
    logic [`DATA_W-1:0] rdata_reg, rdata_next;

    // Pin synchronisers; first stage read only by second
    logic [2:0] flag_s1_reg, flag_s2_reg;
    logic [`WORD_W-1:0] word_s1_reg, word_s2_reg;
    fifo_host_pkg::flags_type flags;

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            flag_s1_reg <= 3'h0;
            flag_s2_reg <= 3'h0;
            word_s1_reg <= 9'h000;
            word_s2_reg <= 9'h000;
        end
        else
        begin
            flag_s1_reg <= {chain_or_half_out_n, no_room_flag_n,
                drained_flag_n};
            flag_s2_reg <= flag_s1_reg;
            word_s1_reg <= pop_word;
            word_s2_reg <= word_s1_reg;
        end
    end

    // Half flag only means something in single mode
    assign flags = {mode_reg.single & ~flag_s2_reg[2], ~flag_s2_reg[1:0]};

    logic wr_ctrl, wr_push, wr_pop, wr_status, rd_pop_data, idle;
    assign idle = (state_reg == fifo_host_pkg::ST_IDLE);
    assign wr_ctrl = wr_en && (addr == `OFS_CTRL);
    assign wr_push = wr_en && (addr == `OFS_PUSH);
    assign wr_pop = wr_en && (addr == `OFS_POP);
    assign wr_status = wr_en && (addr == `OFS_STATUS);
    assign rd_pop_data = rd_en && (addr == `OFS_POP_DATA);

    always_comb
    begin
        logic refuse;
        refuse = 1'b0;
        state_next = state_reg;
        count_next = count_reg;
        push_word_next = push_word_reg;
        pop_data_next = pop_data_reg;
        pop_valid_next = pop_valid_reg;
        cleared_next = cleared_reg;
        mode_next = mode_reg;
        push_n_next = push_n_reg;
        pop_n_next = pop_n_reg;
        clear_n_next = clear_n_reg;
        replay_n_next = replay_n_reg;
        if (rd_pop_data)
            pop_valid_next = 1'b0;
        case (state_reg)
            fifo_host_pkg::ST_IDLE:
            begin
                if (wr_ctrl)
                begin
                    mode_next.single = wdata[`CTRL_SINGLE];
                    mode_next.lead = wdata[`CTRL_LEAD];
                    if (wdata[`CTRL_CLEAR])
                    begin
                        // Strobes already high in idle
                        clear_n_next = 1'b0;
                        count_next = 4'(`CLEAR_CYC);
                        state_next = fifo_host_pkg::ST_CLEAR;
                    end
                    else if (wdata[`CTRL_REPLAY])
                    begin
                        // Replay has no meaning when chained
                        if (mode_reg.single)
                        begin
                            replay_n_next = 1'b0;
                            count_next = 4'(`REPLAY_CYC);
                            state_next = fifo_host_pkg::ST_REPLAY;
                        end
                        else
                            refuse = 1'b1;
                    end
                end
                else if (wr_push)
                begin
                    // No push before clear, none into full
                    if (!cleared_reg || flags.full)
                        refuse = 1'b1;
                    else
                    begin
                        push_word_next = wdata[`WORD_W-1:0];
                        push_n_next = 1'b0;
                        count_next = 4'(`PUSH_CYC);
                        state_next = fifo_host_pkg::ST_PUSH;
                    end
                end
                else if (wr_pop)
                begin
                    if (!cleared_reg || flags.empty)
                        refuse = 1'b1;
                    else
                    begin
                        pop_n_next = 1'b0;
                        count_next = 4'(`POP_CYC);
                        state_next = fifo_host_pkg::ST_POP;
                    end
                end
            end
            fifo_host_pkg::ST_CLEAR:
            begin
                count_next = count_reg - 4'h1;
                if (count_reg == 4'h1)
                begin
                    clear_n_next = 1'b1;
                    cleared_next = 1'b1;
                    count_next = 4'(`CLEAR_REC_CYC);
                    state_next = fifo_host_pkg::ST_CLEAR_REC;
                end
            end
            fifo_host_pkg::ST_CLEAR_REC:
            begin
                // Hold strobes for recovery, then let flags settle
                count_next = count_reg - 4'h1;
                if (count_reg == 4'h1)
                begin
                    count_next = 4'(`SETTLE_CYC);
                    state_next = fifo_host_pkg::ST_SETTLE;
                end
            end
            fifo_host_pkg::ST_PUSH:
            begin
                count_next = count_reg - 4'h1;
                if (count_reg == 4'h1)
                begin
                    push_n_next = 1'b1;
                    count_next = 4'(`SETTLE_CYC);
                    state_next = fifo_host_pkg::ST_SETTLE;
                end
            end
            fifo_host_pkg::ST_POP:
            begin
                count_next = count_reg - 4'h1;
                if (count_reg == 4'h1)
                begin
                    // Word taken just before the strobe rises
                    pop_n_next = 1'b1;
                    pop_data_next = word_s2_reg;
                    pop_valid_next = 1'b1;
                    count_next = 4'(`SETTLE_CYC);
                    state_next = fifo_host_pkg::ST_SETTLE;
                end
            end
            fifo_host_pkg::ST_REPLAY:
            begin
                count_next = count_reg - 4'h1;
                if (count_reg == 4'h1)
                begin
                    replay_n_next = 1'b1;
                    count_next = 4'(`SETTLE_CYC + `REPLAY_REC_CYC);
                    state_next = fifo_host_pkg::ST_SETTLE;
                end
            end
            fifo_host_pkg::ST_SETTLE:
            begin
                // Flags must pass the synchronisers before next order
                count_next = count_reg - 4'h1;
                if (count_reg == 4'h1)
                    state_next = fifo_host_pkg::ST_IDLE;
            end
            default:
            begin
                state_next = fifo_host_pkg::ST_IDLE;
                push_n_next = 1'b1;
                pop_n_next = 1'b1;
                clear_n_next = 1'b1;
                replay_n_next = 1'b1;
            end
        endcase
        if (!idle && (wr_ctrl || wr_push || wr_pop))
            refuse = 1'b1;
        // New refusal wins over the clear
        refused_next = refuse ? 1'b1 :
            ((wr_status && wdata[`STATUS_REFUSED]) ? 1'b0 : refused_reg);
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (rd_en)
        begin
            case (addr)
                `OFS_CTRL:
                    rdata_next = {28'h000_0000, mode_reg.lead,
                        mode_reg.single, 2'h0};
                `OFS_PUSH:
                    rdata_next = {23'h00_0000, push_word_reg};
                `OFS_STATUS:
                    rdata_next = {25'h000_0000, pop_valid_reg, refused_reg,
                        cleared_reg, flags, ~idle};
                `OFS_POP_DATA:
                    rdata_next = {22'h00_0000, pop_valid_reg, pop_data_reg};
                default:
                    rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state_reg <= fifo_host_pkg::ST_IDLE;
            count_reg <= 4'h0;
            push_word_reg <= 9'h000;
            pop_data_reg <= 9'h000;
            pop_valid_reg <= 1'b0;
            cleared_reg <= 1'b0;
            refused_reg <= 1'b0;
            mode_reg <= {`CTRL_RESET_LEAD, `CTRL_RESET_SINGLE};
            push_n_reg <= 1'b1;
            pop_n_reg <= 1'b1;
            clear_n_reg <= 1'b1;
            replay_n_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
            push_word_reg <= push_word_next;
            pop_data_reg <= pop_data_next;
            pop_valid_reg <= pop_valid_next;
            cleared_reg <= cleared_next;
            refused_reg <= refused_next;
            mode_reg <= mode_next;
            push_n_reg <= push_n_next;
            pop_n_reg <= pop_n_next;
            clear_n_reg <= clear_n_next;
            replay_n_reg <= replay_n_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign push_word = push_word_reg;
    assign push_strobe_n = push_n_reg;
    assign pop_pulse_n = pop_n_reg;
    assign clear_pulse_n = clear_n_reg;
    // Shared pin: replay in single mode, lead strap when chained
    assign lead_or_replay_n = mode_reg.single ? replay_n_reg : ~mode_reg.lead;
    // Tied low selects single mode; high otherwise
    assign chain_in_n = ~mode_reg.single;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence clear_rise_s;
        $rose(clear_pulse_n);
    endsequence
    sequence strobes_quiet_s;
        push_strobe_n && pop_pulse_n;
    endsequence

    a_push_after_clear: assert property (
        $fell(push_strobe_n) |-> cleared_reg)
        else $error("push strobe before any clear");
    a_clear_strobes_high: assert property (
        !clear_pulse_n |-> strobes_quiet_s)
        else $error("strobe low during clear");
    a_clear_recovery: assert property (
        clear_rise_s |-> strobes_quiet_s [*3])
        else $error("strobe moved inside clear recovery");
    a_clear_width: assert property (
        $fell(clear_pulse_n) |-> !clear_pulse_n ##1 clear_pulse_n)
        else $error("clear pulse width wrong");

    a_replay_strobes_high: assert property (
        (mode_reg.single && !lead_or_replay_n) |-> strobes_quiet_s)
        else $error("strobe low during replay");

    a_push_not_full: assert property (
        $fell(push_strobe_n) |-> $past(!flags.full))
        else $error("push issued while full");
    a_pop_not_empty: assert property (
        $fell(pop_pulse_n) |-> $past(!flags.empty))
        else $error("pop issued while empty");

    a_pop_capture: assert property (
        $fell(pop_pulse_n) |-> !pop_pulse_n [*3] ##1
            (pop_pulse_n && pop_valid_reg))
        else $error("pop pulse did not yield a word");

endmodule // fifo_host

`default_nettype wire

// ===== fifo_host_defs.svh
// Constants for the strobed FIFO host controller
// How it works
// - Clear pulse issued before any push allowed
// - Strobes high around and after clear rise
// - Strobes stay high during replay pulse
// - Writer watches full, reader watches empty
`ifndef FIFO_HOST_DEFS_SVH
`define FIFO_HOST_DEFS_SVH

`define WORD_W 9
`define ADDR_W 8
`define DATA_W 32

`define OFS_CTRL 8'h00
`define OFS_PUSH 8'h04
`define OFS_POP 8'h08
`define OFS_STATUS 8'h0C
`define OFS_POP_DATA 8'h10

`define CTRL_CLEAR 0
`define CTRL_REPLAY 1
`define CTRL_SINGLE 2
`define CTRL_LEAD 3
`define CTRL_RESET_SINGLE 1'h1
`define CTRL_RESET_LEAD 1'h0
`define STATUS_REFUSED 5

`define T_CLK_NS 40
`define T_CLEAR_NS 15
`define T_CLEAR_REC_NS 10
`define T_PUSH_NS 15
`define T_REPLAY_NS 15
`define T_REPLAY_REC_NS 10
`define T_FLAG_NS 25
`define T_ACCESS_NS 30
`define SYNC_CYC 2

`define CEIL_CYC(t) (((t) + `T_CLK_NS - 1) / `T_CLK_NS)
`define CLEAR_CYC `CEIL_CYC(`T_CLEAR_NS)
`define CLEAR_REC_CYC `CEIL_CYC(`T_CLEAR_REC_NS)
`define PUSH_CYC `CEIL_CYC(`T_PUSH_NS)
`define REPLAY_CYC `CEIL_CYC(`T_REPLAY_NS)
`define REPLAY_REC_CYC `CEIL_CYC(`T_REPLAY_REC_NS)
`define SETTLE_CYC (`CEIL_CYC(`T_FLAG_NS) + `SYNC_CYC)
`define POP_CYC (`CEIL_CYC(`T_ACCESS_NS) + `SYNC_CYC)

`endif

// ===== fifo_host_pkg.sv
// Types for the strobed FIFO host controller
package fifo_host_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CLEAR,
        ST_CLEAR_REC,
        ST_PUSH,
        ST_POP,
        ST_REPLAY,
        ST_SETTLE
    } state_type;

    // Flags as seen after synchronising, active high
    typedef struct packed {
        logic half;
        logic full;
        logic empty;
    } flags_type;

    typedef struct packed {
        logic lead;
        logic single;
    } mode_type;
endpackage

// ===== fifo_host_tb_top.sv
// Self-checking bench for the strobed FIFO host controller
`timescale 1ns/10ps
`default_nettype none
`include "fifo_host_defs.svh"

module fifo_host_tb_top;
    localparam int DEPTH = 256;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata, st;
    logic [8:0] push_word, pop_word, q[$], hist[$];
    logic push_strobe_n, no_room_flag_n, pop_pulse_n, drained_flag_n;
    logic clear_pulse_n, lead_or_replay_n, chain_in_n, chain_or_half_out_n;
    logic cleared = 1'b0;
    int seed = 95;
    int n_errors = 0;
    int cmp_count = 0;

    fifo_host fifo_host_i (.mclk, .rstn, .addr, .wdata, .wr_en, .rd_en,
        .rdata, .push_word, .push_strobe_n, .no_room_flag_n, .pop_word,
        .pop_pulse_n, .drained_flag_n, .clear_pulse_n, .lead_or_replay_n,
        .chain_in_n, .chain_or_half_out_n);
    fifo_dev_model #(.DEPTH(DEPTH)) fifo_dev_model_i (.push_word,
        .push_strobe_n, .no_room_flag_n, .pop_word, .pop_pulse_n,
        .drained_flag_n, .clear_pulse_n, .lead_or_replay_n, .chain_in_n,
        .chain_or_half_out_n);

    initial forever #20 mclk = ~mclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic logic [2:0] exp_flags(input int n);
        return {n > DEPTH / 2, n == DEPTH, n == 0};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    // Bounded poll of busy; a hang here counts as a mismatch
    task automatic idle();
        int k;
        k = 0;
        rd(`OFS_STATUS, st);
        while (st[0] !== 1'b0 && k < 40)
        begin
            rd(`OFS_STATUS, st);
            k++;
        end
        if (k == 40)
            check(32'(st[0]), 32'h0);
    endtask

    task automatic ctrl(input logic [31:0] v);
        wr(`OFS_CTRL, v);
        idle();
    endtask

    task automatic op(input logic is_pop, input logic [8:0] d);
        logic [31:0] r;
        logic acc;
        acc = cleared && (is_pop ? q.size() != 0 : q.size() != DEPTH);
        wr(is_pop ? `OFS_POP : `OFS_PUSH, {23'h0, d});
        idle();
        check(32'(st[5]), 32'(!acc));
        if (!acc)
            wr(`OFS_STATUS, 32'h20);
        else if (is_pop)
        begin
            rd(`OFS_POP_DATA, r);
            check(r, {22'h0, 1'b1, q.pop_front()});
            rd(`OFS_POP_DATA, r);
            check(32'(r[9]), 32'h0);
        end
        else
        begin
            rd(`OFS_PUSH, r);
            check(r, {23'h0, d});
            q.push_back(d);
            hist.push_back(d);
        end
        if (cleared)
            check(32'(st[3:1]), 32'(exp_flags(q.size())));
    endtask

    task automatic do_clear();
        ctrl(32'h5);
        q.delete();
        hist.delete();
        cleared = 1'b1;
        check(32'(st[4:1]), 32'h9);
    endtask

    // Skip the edges out of reset, where the strobes settle in the same step
    always @(posedge clear_pulse_n)
        if (rstn)
            check(32'({push_strobe_n, pop_pulse_n}), 32'h3);
    always @(negedge lead_or_replay_n)
        if (rstn)
            check(32'({push_strobe_n, pop_pulse_n}), 32'h3);

    // About 9.4k cycles expected; 50k cycles is ample margin
    initial
    begin
        #2000000;
        n_errors++;
        give_verdict;
    end

    initial
    begin
        int i;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        rd(`OFS_CTRL, st);
        check(st, 32'h4);
        op(1'b0, 9'h1A5);
        op(1'b1, 9'h000);
        do_clear();
        for (i = 0; i < DEPTH + 1; i++)
            op(1'b0, 9'($random(seed)));
        op(1'b1, 9'h000);
        op(1'b0, 9'($random(seed)));
        while (q.size() != 0)
            op(1'b1, 9'h000);
        op(1'b1, 9'h000);
        do_clear();
        for (i = 0; i < DEPTH / 2 + 2; i++)
            op(1'b0, 9'($random(seed)));
        for (i = 0; i < DEPTH / 2 + 2; i++)
            op(1'b1, 9'h000);
        ctrl(32'h6);
        q = hist;
        check(32'(st[3:1]), 32'(exp_flags(q.size())));
        for (i = 0; i < 3; i++)
            op(1'b1, 9'h000);
        ctrl(32'h8);
        check(32'({chain_in_n, lead_or_replay_n}), 32'h2);
        ctrl(32'hA);
        check(32'(st[5]), 32'h1);
        wr(`OFS_STATUS, 32'h20);
        ctrl(32'h4);
        check(32'({chain_in_n, lead_or_replay_n}), 32'h1);
        give_verdict;
    end
endmodule // fifo_host_tb_top

`default_nettype wire
